// file: rtl/cfg_pkg.sv
// Constants and types shared by both ends of the configuration port
package cfg_pkg;

  // Port select on the link
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA  = 1'b1;

  // Configuration register indexes
  localparam int          NUM_REGS = 8;
  localparam logic [7:0]  IDX_FER  = 8'h00;
  localparam logic [7:0]  IDX_FAR  = 8'h01;
  localparam logic [7:0]  IDX_PTR  = 8'h02;
  localparam logic [7:0]  IDX_FCR  = 8'h03;
  localparam logic [7:0]  IDX_PCR  = 8'h04;
  localparam logic [7:0]  IDX_PMC  = 8'h05;
  localparam logic [7:0]  IDX_TUP  = 8'h06;
  localparam logic [7:0]  IDX_SID  = 8'h07;

  // Pointer layout and reset values
  localparam logic [7:0]  POINTER_RSVD_MASK = 8'h70;
  localparam logic [7:0]  POINTER_RST       = 8'h00;
  localparam logic [7:0]  SOFT_REG_RST      = 8'h00;
  localparam logic [7:0]  PROBE_SECOND      = 8'h00;

  // Strap default values
  localparam logic [7:0]  FER_ALL      = 8'h4f;
  localparam logic [7:0]  FER_ONE_UART = 8'h4b;
  localparam logic [7:0]  FER_NO_IDE   = 8'h0f;
  localparam logic [7:0]  FER_FDC_IDE  = 8'h49;
  localparam logic [7:0]  FER_UARTS    = 8'h07;
  localparam logic [7:0]  FER_IDE_UART = 8'h47;
  localparam logic [7:0]  FER_FDC_ONLY = 8'h08;
  localparam logic [7:0]  FER_NONE     = 8'h00;
  localparam logic [7:0]  FER_SEC_IDE  = 8'h80;
  localparam logic [7:0]  PTR_CLOCKS   = 8'h00;
  localparam logic [7:0]  PTR_XTAL     = 8'h02;
  localparam logic [7:0]  PTR_HI_BIT   = 8'h80;

  // Field positions
  localparam int FER_FDC_SEC_BIT = 5;
  localparam int FER_IDE_SEC_BIT = 7;
  localparam int PTR_XTAL_BIT    = 1;

  // Host I/O ranges
  localparam logic [9:0]  SERIAL_RANGE_A  = 10'h3f8;
  localparam logic [9:0]  SERIAL_RANGE_B  = 10'h2f8;
  localparam logic [9:0]  SERIAL_RANGE_C  = 10'h3e8;
  localparam logic [9:0]  SERIAL_RANGE_D  = 10'h2e8;
  localparam logic [9:0]  PRINTER_RANGE_A = 10'h3bc;
  localparam logic [9:0]  PRINTER_RANGE_B = 10'h378;
  localparam logic [9:0]  PRINTER_RANGE_C = 10'h278;
  localparam logic [9:0]  FDC_PRIMARY     = 10'h3f0;
  localparam logic [9:0]  FDC_SECONDARY   = 10'h370;
  localparam logic [9:0]  IDE_PRIMARY     = 10'h1f0;
  localparam logic [9:0]  IDE_PRI_CTL     = 10'h3f6;
  localparam logic [9:0]  IDE_SECONDARY   = 10'h170;
  localparam logic [9:0]  IDE_SEC_CTL     = 10'h376;

  // Host command port offsets
  localparam logic [1:0]  HOST_REG_INDEX  = 2'h0;
  localparam logic [1:0]  HOST_REG_VALUE  = 2'h1;
  localparam logic [1:0]  HOST_REG_CMD    = 2'h2;
  localparam logic [1:0]  HOST_REG_STATUS = 2'h3;

  // Host commands
  localparam logic [1:0]  CMD_LOAD  = 2'h1;
  localparam logic [1:0]  CMD_READ  = 2'h2;
  localparam logic [1:0]  CMD_PROBE = 2'h3;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_W1   = 3'b001,
    H_W2   = 3'b010,
    H_RD   = 3'b011,
    H_WAIT = 3'b100,
    H_CAP  = 3'b101
  } host_state_t;

  typedef enum logic [1:0] {
    PH_DATA   = 2'b00,
    PH_FIRST  = 2'b01,
    PH_SECOND = 2'b10
  } probe_phase_t;

endpackage

// file: rtl/cfg_io_if.sv
// Index/data port link between host and configuration unit
`timescale 1ns/1ps
interface cfg_io_if;
  logic       io_sel;
  logic [7:0] io_wdata;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_rdata;

  modport dev  (input io_sel, input io_wdata, input io_wr, input io_rd,
                output io_rdata);
  modport host (output io_sel, output io_wdata, output io_wr,
                output io_rd, input io_rdata);
endinterface

// file: rtl/cfg_strap_defaults.sv
// Strap code to default register values lookup
`timescale 1ns/1ps
module cfg_strap_defaults
(
  // Straps
  input  wire logic [4:0] default_select_straps,
  input  wire logic       ptr_high,
  // Defaults
  output logic [7:0]      fer_default,
  output logic [7:0]      far_default,
  output logic [7:0]      ptr_default
);
  import cfg_pkg::*;

  logic       sec_ide;
  logic [7:0] fer_base;

  always_comb
  begin
    sec_ide  = 1'b0;
    fer_base = FER_NONE;
    far_default = 8'h10;
    ptr_default = PTR_CLOCKS | (ptr_high ? PTR_HI_BIT : 8'h00);
    case (default_select_straps)
      5'h00: begin fer_base = FER_ALL; far_default = 8'h10; end
      5'h01: begin fer_base = FER_ALL; far_default = 8'h11; end
      5'h02:
      begin
        fer_base = FER_ALL; far_default = 8'h11; sec_ide = 1'b1;
      end
      5'h03: begin fer_base = FER_ALL; far_default = 8'h39; end
      5'h04: begin fer_base = FER_ALL; far_default = 8'h24; end
      5'h05:
      begin
        fer_base = FER_ALL; far_default = 8'h38; sec_ide = 1'b1;
      end
      5'h06: begin fer_base = FER_ONE_UART; far_default = 8'h00; end
      5'h07: begin fer_base = FER_ONE_UART; far_default = 8'h01; end
      5'h08:
      begin
        fer_base = FER_ONE_UART; far_default = 8'h01; sec_ide = 1'b1;
      end
      5'h09: begin fer_base = FER_ONE_UART; far_default = 8'h09; end
      5'h0a: begin fer_base = FER_ONE_UART; far_default = 8'h08; end
      5'h0b:
      begin
        fer_base = FER_ONE_UART; far_default = 8'h08; sec_ide = 1'b1;
      end
      5'h0c: begin fer_base = FER_NO_IDE; far_default = 8'h10; end
      5'h0d: begin fer_base = FER_NO_IDE; far_default = 8'h11; end
      5'h0e: begin fer_base = FER_NO_IDE; far_default = 8'h39; end
      5'h0f: begin fer_base = FER_NO_IDE; far_default = 8'h24; end
      5'h10: begin fer_base = FER_FDC_IDE; far_default = 8'h00; end
      5'h11: begin fer_base = FER_FDC_IDE; far_default = 8'h01; end
      5'h12:
      begin
        fer_base = FER_FDC_IDE; far_default = 8'h01; sec_ide = 1'b1;
      end
      5'h13:
      begin
        fer_base = FER_FDC_IDE; far_default = 8'h00; sec_ide = 1'b1;
      end
      5'h14: begin fer_base = FER_UARTS; far_default = 8'h10; end
      5'h15: begin fer_base = FER_UARTS; far_default = 8'h11; end
      5'h16: begin fer_base = FER_UARTS; far_default = 8'h39; end
      5'h17: begin fer_base = FER_UARTS; far_default = 8'h24; end
      5'h18: begin fer_base = FER_IDE_UART; far_default = 8'h10; end
      5'h19: begin fer_base = FER_IDE_UART; far_default = 8'h11; end
      5'h1a:
      begin
        fer_base = FER_IDE_UART; far_default = 8'h11; sec_ide = 1'b1;
      end
      5'h1b: begin fer_base = FER_IDE_UART; far_default = 8'h39; end
      5'h1c: begin fer_base = FER_IDE_UART; far_default = 8'h24; end
      5'h1d:
      begin
        fer_base = FER_IDE_UART; far_default = 8'h38; sec_ide = 1'b1;
      end
      5'h1e: begin fer_base = FER_FDC_ONLY; far_default = 8'h10; end
      5'h1f:
      begin
        fer_base = FER_NONE;
        far_default = 8'h10;
        ptr_default = PTR_XTAL | (ptr_high ? PTR_HI_BIT : 8'h00);
      end
      default: begin fer_base = FER_NONE; far_default = 8'h10; end
    endcase
    fer_default = fer_base | (sec_ide ? FER_SEC_IDE : 8'h00);
  end

endmodule

// file: rtl/cfg_device.sv
// Configuration register unit reached through an index/data port pair
// Notes on behaviour
// - Eight base configuration registers are held.
// - Reset loads straps into first three only.
// - Index port selects, data port transfers contents.
// - First index read after reset returns ID if no index write came before it.
// - Second probe read of index returns zero.
// - Later index reads return last written pointer.
// - Pointer bits four to six read zero.
// - Host writes index once, interrupts disabled.
// - Register updates on second consecutive data write.
// - Data read returns indexed register and cancels a pending data write.
// - Host read-modify-write uses two data writes.
// - Five straps pick one of 32 defaults.
// - Strap defaults stay writable after reset.
// - Power/test default lets power-down stop clocks.
// - Codes 00000-00101 defaults, first group.
// - Codes 00110-01011 defaults, second group.
// - Codes 01100-01111 defaults, third group.
// - Codes 10000-10111 defaults, fourth and fifth groups.
// - Codes 11000-11101 defaults, sixth group.
// - Codes 11110 and 11111, last two cases.
// - Serial codes decode to four serial ranges.
// - Floppy, IDE and printer ranges decode.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module cfg_device
#(
  // Arbitrary identity value, no meaning beyond this design
  parameter logic [7:0] CHIP_ID = 8'h5a
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Link to host
  cfg_io_if.dev           io,
  // Straps and power control
  input  wire logic [4:0] default_select_straps,
  input  wire logic       ptr_high_strap,
  input  wire logic       power_down_input,
  // Register contents
  output logic [7:0]      function_enable_reg,
  output logic [7:0]      function_address_reg,
  output logic [7:0]      power_test_reg,
  output logic [7:0]      function_control_reg,
  output logic [7:0]      printer_control_reg,
  output logic [7:0]      power_management_reg,
  output logic [7:0]      tape_port_config_reg,
  // Decoded ranges
  output logic [9:0]      serial_range_1,
  output logic [9:0]      serial_range_2,
  output logic [9:0]      printer_range,
  output logic [9:0]      fdc_range,
  output logic [9:0]      ide_range,
  output logic [9:0]      ide_ctl_range,
  // Power
  output logic            clocks_stop,
  output logic            xtal_stop
);
  import cfg_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] cfg;
    logic [7:0]               pointer;
    logic                     id_done;
    logic                     pending;
    logic [7:0]               rdata;
    logic [9:0]               ser1;
    logic [9:0]               ser2;
    logic [9:0]               prn;
    logic [9:0]               fdc;
    logic [9:0]               ide;
    logic [9:0]               ide_ctl;
    logic                     clk_stop;
    logic                     xtl_stop;
  } dev_state_t;

  dev_state_t st;
  dev_state_t next_st;
  logic [7:0] fer_default;
  logic [7:0] far_default;
  logic [7:0] ptr_default;

  // Serial range code decode
  function automatic logic [9:0] serial_decode(input logic [1:0] code);
    case (code)
      2'b00:   serial_decode = SERIAL_RANGE_A;
      2'b01:   serial_decode = SERIAL_RANGE_B;
      2'b10:   serial_decode = SERIAL_RANGE_C;
      default: serial_decode = SERIAL_RANGE_D;
    endcase
  endfunction

  // Index to register slot, valid when its low seven bits are within the base set
  function automatic logic idx_valid(input logic [7:0] idx);
    idx_valid = (idx[6:0] < 7'(NUM_REGS));
  endfunction

  function automatic logic [2:0] idx_slot(input logic [7:0] idx);
    idx_slot = idx[2:0];
  endfunction

  cfg_strap_defaults cfg_strap_defaults_inst
  (
    .default_select_straps (default_select_straps),
    .ptr_high              (ptr_high_strap),
    .fer_default           (fer_default),
    .far_default           (far_default),
    .ptr_default           (ptr_default)
  );

  always_comb
  begin
    next_st = st;
    if (sys_rst)
    begin
      next_st = '0;
      for (int i = 0; i < NUM_REGS; i++)
        next_st.cfg[i] = SOFT_REG_RST;
      next_st.cfg[IDX_FER[2:0]] = fer_default;
      next_st.cfg[IDX_FAR[2:0]] = far_default;
      next_st.cfg[IDX_PTR[2:0]] = ptr_default;
      next_st.cfg[IDX_SID[2:0]] = CHIP_ID;
      next_st.pointer = POINTER_RST;
      next_st.id_done = 1'b0;
      next_st.pending = 1'b0;
    end
    else
    begin
      if (io.io_rd && io.io_sel == PORT_INDEX)
      begin
        next_st.pending = 1'b0;
        if (!st.id_done)
        begin
          next_st.rdata   = CHIP_ID;
          next_st.id_done = 1'b1;
        end
        else
          next_st.rdata = st.pointer & ~POINTER_RSVD_MASK;
      end
      else if (io.io_rd && io.io_sel == PORT_DATA)
      begin
        next_st.pending = 1'b0;
        if (idx_valid(st.pointer))
          next_st.rdata = st.cfg[idx_slot(st.pointer)];
        else
          next_st.rdata = 8'h00;
      end
      else if (io.io_wr && io.io_sel == PORT_INDEX)
      begin
        next_st.pointer = io.io_wdata & ~POINTER_RSVD_MASK;
        next_st.id_done = 1'b1;
        next_st.pending = 1'b0;
      end
      else if (io.io_wr && io.io_sel == PORT_DATA)
      begin
        if (!st.pending)
          next_st.pending = 1'b1;
        else
        begin
          next_st.pending = 1'b0;
          if (idx_valid(st.pointer) && idx_slot(st.pointer) !=
              IDX_SID[2:0])
            next_st.cfg[idx_slot(st.pointer)] = io.io_wdata;
        end
      end
    end
    // Range decode from current contents
    next_st.ser1 = serial_decode(st.cfg[IDX_FAR[2:0]][3:2]);
    next_st.ser2 = serial_decode(st.cfg[IDX_FAR[2:0]][5:4]);
    case (st.cfg[IDX_FAR[2:0]][1:0])
      2'b00:   next_st.prn = PRINTER_RANGE_B;
      2'b01:   next_st.prn = PRINTER_RANGE_A;
      2'b10:   next_st.prn = PRINTER_RANGE_C;
      default: next_st.prn = 10'h000;
    endcase
    next_st.fdc = st.cfg[IDX_FER[2:0]][FER_FDC_SEC_BIT] ?
                  FDC_SECONDARY : FDC_PRIMARY;
    next_st.ide = st.cfg[IDX_FER[2:0]][FER_IDE_SEC_BIT] ?
                  IDE_SECONDARY : IDE_PRIMARY;
    next_st.ide_ctl = st.cfg[IDX_FER[2:0]][FER_IDE_SEC_BIT] ?
                      IDE_SEC_CTL : IDE_PRI_CTL;
    // Power-down stops clocks, crystal too when enabled
    next_st.clk_stop = power_down_input;
    next_st.xtl_stop = power_down_input &
                       st.cfg[IDX_PTR[2:0]][PTR_XTAL_BIT];
  end

  always_ff @(posedge ref_clk)
    st <= next_st;

  assign io.io_rdata           = st.rdata;
  assign function_enable_reg   = st.cfg[IDX_FER[2:0]];
  assign function_address_reg  = st.cfg[IDX_FAR[2:0]];
  assign power_test_reg        = st.cfg[IDX_PTR[2:0]];
  assign function_control_reg  = st.cfg[IDX_FCR[2:0]];
  assign printer_control_reg   = st.cfg[IDX_PCR[2:0]];
  assign power_management_reg  = st.cfg[IDX_PMC[2:0]];
  assign tape_port_config_reg  = st.cfg[IDX_TUP[2:0]];
  assign serial_range_1        = st.ser1;
  assign serial_range_2        = st.ser2;
  assign printer_range         = st.prn;
  assign fdc_range             = st.fdc;
  assign ide_range             = st.ide;
  assign ide_ctl_range         = st.ide_ctl;
  assign clocks_stop           = st.clk_stop;
  assign xtal_stop             = st.xtl_stop;

endmodule

// file: rtl/cfg_host.sv
// Host end that runs load, read and probe sequences on the port pair
`timescale 1ns/1ps
module cfg_host
#(
  // Expected identity value, arbitrary
  parameter logic [7:0] EXPECT_ID = 8'h5a
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Command port
  input  wire logic [1:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  output logic [7:0]      cmd_rdata,
  // Link to device
  cfg_io_if.host          io
);
  import cfg_pkg::*;

  typedef struct packed {
    host_state_t  state;
    probe_phase_t phase;
    logic [7:0]   index;
    logic [7:0]   value;
    logic [7:0]   rval;
    logic         busy;
    logic         found;
    logic         id_ok;
    logic [7:0]   rdata;
    logic         sel;
    logic [7:0]   wdata;
    logic         wr;
    logic         rd;
  } host_st_t;

  host_st_t st;
  host_st_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    if (cmd_wr && cmd_addr == HOST_REG_INDEX)
      next_st.index = cmd_wdata;
    if (cmd_wr && cmd_addr == HOST_REG_VALUE)
      next_st.value = cmd_wdata;
    if (cmd_rd)
      case (cmd_addr)
        HOST_REG_INDEX:  next_st.rdata = st.index;
        HOST_REG_VALUE:  next_st.rdata = st.rval;
        HOST_REG_STATUS: next_st.rdata = {5'h00, st.id_ok, st.found,
                                          st.busy};
        default:         next_st.rdata = 8'h00;
      endcase
    case (st.state)
      H_IDLE:
        if (cmd_wr && cmd_addr == HOST_REG_CMD && cmd_wdata[1:0] != 2'b00)
        begin
          next_st.busy = 1'b1;
          if (cmd_wdata[1:0] == CMD_PROBE)
          begin
            next_st.rd    = 1'b1;
            next_st.sel   = PORT_INDEX;
            next_st.phase = PH_FIRST;
            next_st.found = 1'b0;
            next_st.id_ok = 1'b0;
            next_st.state = H_WAIT;
          end
          else
          begin
            next_st.wr    = 1'b1;
            next_st.sel   = PORT_INDEX;
            next_st.wdata = st.index;
            next_st.state = (cmd_wdata[1:0] == CMD_LOAD) ? H_W1 : H_RD;
          end
        end
      H_W1:
      begin
        next_st.wr    = 1'b1;
        next_st.sel   = PORT_DATA;
        next_st.wdata = st.value;
        next_st.state = H_W2;
      end
      H_W2:
      begin
        next_st.wr    = 1'b1;
        next_st.sel   = PORT_DATA;
        next_st.wdata = st.value;
        next_st.busy  = 1'b0;
        next_st.state = H_IDLE;
      end
      H_RD:
      begin
        next_st.rd    = 1'b1;
        next_st.sel   = PORT_DATA;
        next_st.phase = PH_DATA;
        next_st.state = H_WAIT;
      end
      H_WAIT:
        next_st.state = H_CAP;
      H_CAP:
        case (st.phase)
          PH_FIRST:
          begin
            next_st.id_ok = (io.io_rdata == EXPECT_ID);
            next_st.rd    = 1'b1;
            next_st.sel   = PORT_INDEX;
            next_st.phase = PH_SECOND;
            next_st.state = H_WAIT;
          end
          PH_SECOND:
          begin
            next_st.found = st.id_ok && io.io_rdata == PROBE_SECOND;
            next_st.busy  = 1'b0;
            next_st.state = H_IDLE;
          end
          default:
          begin
            next_st.rval  = io.io_rdata;
            next_st.busy  = 1'b0;
            next_st.state = H_IDLE;
          end
        endcase
      default:
        next_st.state = H_IDLE;
    endcase
    if (sys_rst)
    begin
      next_st       = '0;
      next_st.state = H_IDLE;
      next_st.phase = PH_DATA;
    end
  end

  always_ff @(posedge ref_clk)
    st <= next_st;

  assign cmd_rdata   = st.rdata;
  assign io.io_sel   = st.sel;
  assign io.io_wdata = st.wdata;
  assign io.io_wr    = st.wr;
  assign io.io_rd    = st.rd;

endmodule

// file: verif/cfg_link_chk.sv
// Checker for the index/data link between host and device ends
`timescale 1ns/1ps
module cfg_link_chk
#(
  parameter logic [7:0] CHIP_ID = 8'h5a
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Link signals
  input  wire logic       io_sel,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_rdata
);
  logic [7:0] ptr_q;
  logic       id_done;
  logic       pend;
  logic       val_ok;
  logic [7:0] val_q;
  logic [7:0] val_idx;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Pointer, identity and write pairing seen on the link
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ptr_q   <= 8'h00;
      id_done <= 1'b0;
      pend    <= 1'b0;
      val_ok  <= 1'b0;
    end
    else
    begin
      if (io_wr && !io_sel)
        ptr_q <= io_wdata;
      if ((io_wr || io_rd) && !io_sel)
        id_done <= 1'b1;
      if (io_wr || io_rd)
        pend <= io_wr && io_sel && !pend;
      if (io_wr && io_sel && pend)
      begin
        val_ok  <= 1'b1;
        val_q   <= io_wdata;
        val_idx <= ptr_q;
      end
    end
  end

  dual_strobe_a: assert property (!(io_wr && io_rd))
    else $error("read and write strobes at once");
  rdata_holds_a: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
  rd_pulse_a: assert property (io_rd |=> !io_rd)
    else $error("read strobe longer than one cycle");
  id_read_a: assert property (
    io_rd && !io_sel && !id_done |=> io_rdata == CHIP_ID)
    else $error("first index read did not give identity");
  ptr_read_a: assert property (
    io_rd && !io_sel && id_done |=> io_rdata == (ptr_q & 8'h8f))
    else $error("index read differs from pointer");
  high_index_a: assert property (
    io_rd && io_sel && ptr_q[6:0] > 7'h07 |=> io_rdata == 8'h00)
    else $error("unused index read not zero");
  id_slot_a: assert property (
    io_rd && io_sel && ptr_q[6:0] == 7'h07 |=> io_rdata == CHIP_ID)
    else $error("identity register read wrong");
  pair_value_a: assert property (
    io_rd && io_sel && val_ok && ptr_q == val_idx && ptr_q < 8'h07
    |=> io_rdata == val_q)
    else $error("data read differs from paired write");
  pair_write_a: assert property (
    io_wr && io_sel && !$past(io_wr && io_sel) |=> io_wr && io_sel)
    else $error("lone data write from host");
  index_range_a: assert property (
    io_wr && !io_sel |-> io_wdata <= 8'h0e)
    else $error("index written out of range");

  cover property (io_rd && !io_sel && !id_done);
  cover property (io_wr && io_sel && pend);
  cover property (io_rd && io_sel && ptr_q[6:0] > 7'h07);
endmodule

// file: verif/config_index_data_access_bench.sv
// Bench joining host and device ends over the index/data link
`timescale 1ns/1ps
module config_index_data_access_bench;
  import cfg_pkg::*;
  // Arbitrary identity value
  localparam logic [7:0]   ID_VAL  = 8'h5a;
  localparam logic [255:0] FER_TAB =
    256'h0008c74747c7474707070707c9c949490f0f0f0fcb4b4bcb4b4bcf4f4fcf4f4f;
  localparam logic [255:0] FAR_TAB =
    256'h1010382439111110243911100001010024391110080809010100382439111110;
  localparam logic [39:0]  SER_TAB = {10'h2e8, 10'h3e8, 10'h2f8, 10'h3f8};
  localparam logic [39:0]  PRN_TAB = {10'h000, 10'h278, 10'h3bc, 10'h378};

  logic        ref_clk;
  logic        sys_rst;
  logic [1:0]  cmd_addr;
  logic [7:0]  cmd_wdata;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [7:0]  cmd_rdata;
  logic [4:0]  straps;
  logic        ptr_high;
  logic        pwr_down;
  wire  [55:0] all_regs;
  logic [9:0]  ser1;
  logic [9:0]  ser2;
  logic [9:0]  prn_rng;
  logic [9:0]  fdc_rng;
  logic [9:0]  ide_rng;
  logic [9:0]  ctl_rng;
  logic        clk_stop;
  logic        xtal_stop;
  logic [7:0]  v;
  int          k;
  int          n_errors;
  int          n_checks;

  cfg_io_if io ();

  cfg_device #(.CHIP_ID (ID_VAL)) cfg_device_inst
  (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .io                    (io),
    .default_select_straps (straps),
    .ptr_high_strap        (ptr_high),
    .power_down_input      (pwr_down),
    .function_enable_reg   (all_regs[7:0]),
    .function_address_reg  (all_regs[15:8]),
    .power_test_reg        (all_regs[23:16]),
    .function_control_reg  (all_regs[31:24]),
    .printer_control_reg   (all_regs[39:32]),
    .power_management_reg  (all_regs[47:40]),
    .tape_port_config_reg  (all_regs[55:48]),
    .serial_range_1        (ser1),
    .serial_range_2        (ser2),
    .printer_range         (prn_rng),
    .fdc_range             (fdc_rng),
    .ide_range             (ide_rng),
    .ide_ctl_range         (ctl_rng),
    .clocks_stop           (clk_stop),
    .xtal_stop             (xtal_stop)
  );

  cfg_host #(.EXPECT_ID (ID_VAL)) cfg_host_inst
  (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .cmd_addr  (cmd_addr),
    .cmd_wdata (cmd_wdata),
    .cmd_wr    (cmd_wr),
    .cmd_rd    (cmd_rd),
    .cmd_rdata (cmd_rdata),
    .io        (io)
  );

  cfg_link_chk #(.CHIP_ID (ID_VAL)) cfg_link_chk_inst
  (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .io_sel   (io.io_sel),
    .io_wdata (io.io_wdata),
    .io_wr    (io.io_wr),
    .io_rd    (io.io_rd),
    .io_rdata (io.io_rdata)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cwr(input logic [1:0] a, input logic [7:0] d);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic crd(input logic [1:0] a, output logic [7:0] d);
    cmd_addr <= a;
    cmd_rd   <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    @(posedge ref_clk);
    d = cmd_rdata;
  endtask

  task automatic idle();
    logic [7:0] s;
    for (int i = 0; i < 20; i++)
    begin
      crd(HOST_REG_STATUS, s);
      if (s[0] === 1'b0)
        return;
    end
    n_errors++;
    results();
  endtask

  task automatic load(input logic [7:0] i, input logic [7:0] d);
    cwr(HOST_REG_INDEX, i);
    cwr(HOST_REG_VALUE, d);
    cwr(HOST_REG_CMD, 8'(CMD_LOAD));
    idle();
  endtask

  task automatic rdreg(input logic [7:0] i, output logic [7:0] d);
    cwr(HOST_REG_INDEX, i);
    cwr(HOST_REG_CMD, 8'(CMD_READ));
    idle();
    crd(HOST_REG_VALUE, d);
  endtask

  task automatic chk_rng(input logic [7:0] fe, input logic [7:0] fa);
    check(32'(ser1), 32'(SER_TAB[fa[3:2]*10 +: 10]));
    check(32'(ser2), 32'(SER_TAB[fa[5:4]*10 +: 10]));
    check(32'(prn_rng), 32'(PRN_TAB[fa[1:0]*10 +: 10]));
    check(32'(fdc_rng), fe[5] ? 32'h370 : 32'h3f0);
    check(32'(ide_rng), fe[7] ? 32'h170 : 32'h1f0);
    check(32'(ctl_rng), fe[7] ? 32'h376 : 32'h3f6);
  endtask

  initial
  begin
    ref_clk   = 1'b0;
    sys_rst   = 1'b1;
    cmd_addr  = 2'h0;
    cmd_wdata = 8'h00;
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    straps    = 5'h00;
    ptr_high  = 1'b0;
    pwr_down  = 1'b1;
    n_errors  = 0;
    n_checks  = 0;
    repeat (8) @(posedge ref_clk);
    // Every strap code, the last one with both power/test options
    for (int c = 0; c < 33; c++)
    begin
      k = (c > 31) ? 31 : c;
      sys_rst  <= 1'b1;
      straps   <= 5'(k);
      ptr_high <= (c > 31) ? 1'b0 : k[0];
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(32'(all_regs[7:0]), 32'(FER_TAB[k*8 +: 8]));
      check(32'(all_regs[15:8]), 32'(FAR_TAB[k*8 +: 8]));
      v = {ptr_high, 5'h0, k == 31, 1'b0};
      check(32'(all_regs[23:16]), 32'(v));
      check(32'(all_regs[55:24]), 32'h0);
      chk_rng(FER_TAB[k*8 +: 8], FAR_TAB[k*8 +: 8]);
      check(32'(clk_stop), 32'h1);
      check(32'(xtal_stop), 32'(k == 31));
    end
    sys_rst  <= 1'b1;
    straps   <= 5'h00;
    pwr_down <= 1'b0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // Probe twice: identity is given once per reset
    cwr(HOST_REG_CMD, 8'(CMD_PROBE));
    idle();
    crd(HOST_REG_STATUS, v);
    check(32'(v[2:1]), 32'h3);
    cwr(HOST_REG_CMD, 8'(CMD_PROBE));
    idle();
    crd(HOST_REG_STATUS, v);
    check(32'(v[2]), 32'h0);
    check(32'(clk_stop), 32'h0);
    // Load and read back every writable register
    for (int i = 0; i < 7; i++)
      load(8'(i), 8'(8'h90 + i));
    for (int i = 0; i < 7; i++)
    begin
      rdreg(8'(i), v);
      check(32'(v), 32'(8'h90 + i));
      check(32'(all_regs[i*8 +: 8]), 32'(8'h90 + i));
    end
    chk_rng(8'h90, 8'h91);
    // Identity slot and unused index refuse writes
    load(8'h07, 8'h33);
    rdreg(8'h07, v);
    check(32'(v), 32'(ID_VAL));
    load(8'h0e, 8'h44);
    rdreg(8'h0e, v);
    check(32'(v), 32'h0);
    // Read-modify-write of the power/test register
    rdreg(IDX_PTR, v);
    load(IDX_PTR, v ^ 8'h80);
    check(32'(all_regs[23:16]), 32'h12);
    results();
  end
endmodule
